// file: src/gpio_consts.vh
// Purpose: constants for the shared-pin port block
// Assumes: register words use bit 0 = MSB numbering, mapped to verilog bit 31-n
// Notes: definitions only
`ifndef GPIO_CONSTS_VH
`define GPIO_CONSTS_VH

`define ADDR_ARB_DIR 32'h8007FC60
`define ADDR_ARB_ASG 32'h8007FC64
`define ADDR_ARB_DAT 32'h8007FC68
`define ADDR_ABP_ASG 32'h8007FC84
`define ADDR_ABP_DAT 32'h8007FC88
`define ADDR_CTL_DIR 32'h8007FC98
`define ADDR_CTL_ASG 32'h8007FC9C
`define ADDR_CTL_DAT 32'h8007FCA0
`define ADDR_GPIO_CTRL 32'h8007FCF0

`define MASK_ARB_DD 32'h1F000000
`define MASK_ARB_ASG 32'h3F000000
`define MASK_ABP 32'hFFFF0000
`define MASK_CTL 32'hFF7FFF3F
`define MASK_GPIO_CTRL 32'h00000001

`define RST_DIR 32'h00000000
`define RST_ABP_ASG_FIXED 32'hFFF00000
`define RST_ABP_ASG_CFG 32'h000F0000

`define CTRL_USER_DATA 0
`define STAT_PRU_MODE 8

// configuration word positions, verilog index = 31 - word bit
`define CFG_CTL_J 17
`define CFG_CTL_K01 16
`define CFG_CTL_KL 15
`define CFG_CTL_I 14
`define CFG_ARB 13
`define CFG_PRU 6
`define CFG_ADDR_HI 5

// 56-bit pin image: port bytes M,A,B,I,J,K,L
`define PIN_IMPL 56'h1FFFFFFF7FFF3F
`define FUNC_IMPL 56'h3FFFFFFF7FFF3F
`define PIN_OUT_ONLY 56'h00FFFF00000000

`endif

// file: src/system_port_gpio.v
// Purpose: shared bus-pin general purpose ports: arbitration port, two address ports,
//          four bus-control ports, with their register file
// Assumes: pins synchronous to clk_i; config word stable across reset release
// Notes: data latches carry no reset; a per-register written flag masks them until written
`timescale 1ns/1ps
`include "gpio_consts.vh"

module system_port_gpio (
    input wire clk_i,
    input wire nrst_i,
    input wire [31:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire supervisor_i,
    output wire [31:0] rdata_o,
    output wire acc_done_o,
    output wire acc_err_o,
    input wire [31:0] cfg_word_i,
    input wire [11:0] cs_select_i,
    output wire ext_req_o,
    output wire ext_we_o,
    output wire [31:0] ext_addr_o,
    output wire [31:0] ext_wdata_o,
    input wire [7:0] m_pin_i,
    output wire [7:0] m_pin_o,
    output wire [7:0] m_oe_o,
    output wire [7:0] m_func_o,
    output wire strobe_select_o,
    output wire [7:0] a_pin_o,
    output wire [7:0] a_oe_o,
    output wire [7:0] a_func_o,
    output wire [7:0] b_pin_o,
    output wire [7:0] b_oe_o,
    output wire [7:0] b_func_o,
    input wire [7:0] i_pin_i,
    output wire [7:0] i_pin_o,
    output wire [7:0] i_oe_o,
    output wire [7:0] i_func_o,
    input wire [7:0] j_pin_i,
    output wire [7:0] j_pin_o,
    output wire [7:0] j_oe_o,
    output wire [7:0] j_func_o,
    input wire [7:0] k_pin_i,
    output wire [7:0] k_pin_o,
    output wire [7:0] k_oe_o,
    output wire [7:0] k_func_o,
    input wire [7:0] l_pin_i,
    output wire [7:0] l_pin_o,
    output wire [7:0] l_oe_o,
    output wire [7:0] l_func_o
);

// pin n of a port sits at byte bit 7-n
function [7:0] rev8;
    input [7:0] v;
    integer n;
    begin
        for (n = 0; n < 8; n = n + 1) begin
            rev8[n] = v[7 - n];
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg [31:0] arb_dir_ff;
reg [31:0] arb_asg_ff;
reg [31:0] arb_dat_ff;
reg [31:0] abp_asg_ff;
reg [31:0] abp_dat_ff;
reg [31:0] ctl_dir_ff;
reg [31:0] ctl_asg_ff;
reg [31:0] ctl_dat_ff;
reg arb_wr_ff;
reg abp_wr_ff;
reg ctl_wr_ff;
reg user_data_ff;
reg pru_mode_ff;
reg init_ff;
reg [31:0] rdata_ff;
reg done1_ff;
reg long_ff;
reg done2_ff;
reg err_ff;
reg ext_req_ff;
reg ext_we_ff;
reg [31:0] ext_addr_ff;
reg [31:0] ext_wdata_ff;
reg [55:0] in_ff;
reg [55:0] oe_ff;
reg [55:0] out_ff;
reg [55:0] func_ff;
reg strobe_sel_ff;

////////////////////////////////////////////////////////////////////////////////
// address decode and privilege

wire hit_arb_dir = (addr_i == `ADDR_ARB_DIR);
wire hit_arb_asg = (addr_i == `ADDR_ARB_ASG);
wire hit_arb_dat = (addr_i == `ADDR_ARB_DAT);
wire hit_abp_asg = (addr_i == `ADDR_ABP_ASG);
wire hit_abp_dat = (addr_i == `ADDR_ABP_DAT);
wire hit_ctl_dir = (addr_i == `ADDR_CTL_DIR);
wire hit_ctl_asg = (addr_i == `ADDR_CTL_ASG);
wire hit_ctl_dat = (addr_i == `ADDR_CTL_DAT);
wire hit_ctrl = (addr_i == `ADDR_GPIO_CTRL);

wire hit_data = hit_arb_dat | hit_abp_dat | hit_ctl_dat;
wire hit_super = hit_arb_dir | hit_arb_asg | hit_abp_asg | hit_ctl_dir | hit_ctl_asg
    | hit_ctrl;
wire hit_any = hit_data | hit_super;
wire pru_port = hit_abp_asg | hit_abp_dat | hit_ctl_dir | hit_ctl_asg | hit_ctl_dat;
wire redirect = pru_mode_ff & pru_port;
wire priv_ok = supervisor_i | (hit_data & user_data_ff);
wire strobe = wr_i | rd_i;
wire svc = strobe & hit_any & priv_ok & ~redirect;
wire wr_ok = wr_i & svc;

////////////////////////////////////////////////////////////////////////////////
// pin image and per-pin function

// implemented port pins; the others never become port i/o
localparam [55:0] pin_impl = `PIN_IMPL;

// address ports have no direction register: always outputs
function [15:0] abp_dat_mask_dir;
    input one;
    begin
        abp_dat_mask_dir = {16{one}};
    end
endfunction

wire [55:0] asg_all = {arb_asg_ff[31:24], abp_asg_ff[31:16], ctl_asg_ff};
wire [55:0] dir_all = {arb_dir_ff[31:24], abp_dat_mask_dir(1'b1), ctl_dir_ff};
wire [55:0] dat_all = {arb_dat_ff[31:24] & {8{arb_wr_ff}},
    abp_dat_ff[31:16] & {16{abp_wr_ff}}, ctl_dat_ff & {32{ctl_wr_ff}}};
wire [55:0] pin_in = {rev8(m_pin_i), 16'h0000, rev8(i_pin_i), rev8(j_pin_i),
    rev8(k_pin_i), rev8(l_pin_i)};
wire [15:0] cs_img;
wire [55:0] gpio_all;
wire [55:0] disc_in;
wire [55:0] rd_mix;

genvar g;
generate
    for (g = 0; g < 16; g = g + 1) begin : g_cs
        if (g < 12) begin : g_used
            assign cs_img[15 - g] = cs_select_i[g];
        end else begin : g_none
            assign cs_img[15 - g] = 1'b0;
        end
    end
    for (g = 0; g < 56; g = g + 1) begin : g_pin
        wire cs_bit;
        if (g >= 32 && g < 48) begin : g_addr
            assign cs_bit = cs_img[g - 32];
        end else begin : g_other
            assign cs_bit = 1'b0;
        end
        // chip-select role overrides the assignment bit
        assign gpio_all[g] = pin_impl[g] & ~asg_all[g] & ~cs_bit;
        assign disc_in[g] = gpio_all[g] & ~dir_all[g];
        assign rd_mix[g] = disc_in[g] ? in_ff[g] : dat_all[g];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// read mux, unimplemented bits forced to zero

reg [31:0] nxt_rdata;
always @* begin
    nxt_rdata = 32'h00000000;
    if (rd_i && svc) begin
        case (1'b1)
            hit_arb_dir: nxt_rdata = arb_dir_ff & `MASK_ARB_DD;
            hit_arb_asg: nxt_rdata = arb_asg_ff & `MASK_ARB_ASG;
            hit_arb_dat: nxt_rdata = {rd_mix[55:48], 24'h000000} & `MASK_ARB_DD;
            hit_abp_asg: nxt_rdata = abp_asg_ff & `MASK_ABP;
            hit_abp_dat: nxt_rdata = {rd_mix[47:32], 16'h0000};
            hit_ctl_dir: nxt_rdata = ctl_dir_ff & `MASK_CTL;
            hit_ctl_asg: nxt_rdata = ctl_asg_ff & `MASK_CTL;
            hit_ctl_dat: nxt_rdata = rd_mix[31:0] & `MASK_CTL;
            hit_ctrl: begin
                nxt_rdata = 32'h00000000;
                nxt_rdata[`CTRL_USER_DATA] = user_data_ff;
                nxt_rdata[`STAT_PRU_MODE] = pru_mode_ff;
            end
            default: nxt_rdata = 32'h00000000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// control registers with reset; defaults from the config word one edge after release

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        arb_dir_ff <= `RST_DIR;
        ctl_dir_ff <= `RST_DIR;
        arb_asg_ff <= 32'h00000000;
        abp_asg_ff <= `RST_ABP_ASG_FIXED;
        ctl_asg_ff <= 32'h00000000;
        arb_wr_ff <= 1'b0;
        abp_wr_ff <= 1'b0;
        ctl_wr_ff <= 1'b0;
        user_data_ff <= 1'b0;
        pru_mode_ff <= 1'b0;
        init_ff <= 1'b0;
    end else if (!init_ff) begin
        // strap caught by a clock edge, not by the asynchronous reset
        init_ff <= 1'b1;
        pru_mode_ff <= cfg_word_i[`CFG_PRU];
        arb_asg_ff <= {2'h0, {6{cfg_word_i[`CFG_ARB]}}, 24'h000000}
            & `MASK_ARB_ASG;
        abp_asg_ff <= `RST_ABP_ASG_FIXED
            | ({32{cfg_word_i[`CFG_ADDR_HI]}} & `RST_ABP_ASG_CFG);
        ctl_asg_ff <= {{8{cfg_word_i[`CFG_CTL_I]}}, 1'b0, {7{cfg_word_i[`CFG_CTL_J]}},
            {2{cfg_word_i[`CFG_CTL_K01]}}, {6{cfg_word_i[`CFG_CTL_KL]}},
            2'b00, {6{cfg_word_i[`CFG_CTL_KL]}}};
    end else if (wr_ok) begin
        if (hit_arb_dir) begin
            arb_dir_ff <= wdata_i & `MASK_ARB_DD;
        end
        if (hit_arb_asg) begin
            arb_asg_ff <= wdata_i & `MASK_ARB_ASG;
        end
        if (hit_abp_asg) begin
            abp_asg_ff <= wdata_i & `MASK_ABP;
        end
        if (hit_ctl_dir) begin
            ctl_dir_ff <= wdata_i & `MASK_CTL;
        end
        if (hit_ctl_asg) begin
            ctl_asg_ff <= wdata_i & `MASK_CTL;
        end
        if (hit_ctrl) begin
            user_data_ff <= wdata_i[`CTRL_USER_DATA];
        end
        if (hit_arb_dat) begin
            arb_wr_ff <= 1'b1;
        end
        if (hit_abp_dat) begin
            abp_wr_ff <= 1'b1;
        end
        if (hit_ctl_dat) begin
            ctl_wr_ff <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// data latches: no reset, contents survive a reset
// limitation: after a reset the written flags hide the latches until the
// next write, so no unknown power-up value ever reaches a pin

always @(posedge clk_i) begin
    if (wr_ok && init_ff && hit_arb_dat) begin
        arb_dat_ff <= wdata_i & `MASK_ARB_DD;
    end
    if (wr_ok && init_ff && hit_abp_dat) begin
        abp_dat_ff <= wdata_i & `MASK_ABP;
    end
    if (wr_ok && init_ff && hit_ctl_dat) begin
        ctl_dat_ff <= wdata_i & `MASK_CTL;
    end
end

////////////////////////////////////////////////////////////////////////////////
// bus answer, access timing, external redirect

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        rdata_ff <= 32'h00000000;
        done1_ff <= 1'b0;
        long_ff <= 1'b0;
        done2_ff <= 1'b0;
        err_ff <= 1'b0;
        ext_req_ff <= 1'b0;
        ext_we_ff <= 1'b0;
        ext_addr_ff <= 32'h00000000;
        ext_wdata_ff <= 32'h00000000;
    end else begin
        rdata_ff <= nxt_rdata;
        done1_ff <= svc & init_ff;
        long_ff <= pru_port;
        done2_ff <= done1_ff & long_ff;
        // refused access gets no done: software sees only the error pulse
        err_ff <= strobe & hit_any & ~priv_ok & ~redirect & init_ff;
        ext_req_ff <= strobe & redirect & init_ff;
        // redirected access is answered outside; it is only announced here
        if (strobe && redirect) begin
            ext_we_ff <= wr_i;
            ext_addr_ff <= addr_i;
            ext_wdata_ff <= wdata_i;
        end
    end
end

assign rdata_o = rdata_ff;
// short access ends cycle 1, replaceable-port access ends cycle 2
assign acc_done_o = (done1_ff & ~long_ff) | done2_ff;
assign acc_err_o = err_ff;
assign ext_req_o = ext_req_ff;
assign ext_we_o = ext_we_ff;
assign ext_addr_o = ext_addr_ff;
assign ext_wdata_o = ext_wdata_ff;

////////////////////////////////////////////////////////////////////////////////
// pin side: inputs sampled, outputs registered so config lands one cycle late

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        in_ff <= 56'h00000000000000;
        oe_ff <= 56'h00000000000000;
        out_ff <= 56'h00000000000000;
        func_ff <= 56'h00000000000000;
        strobe_sel_ff <= 1'b0;
    end else begin
        in_ff <= pin_in & ~`PIN_OUT_ONLY;
        oe_ff <= gpio_all & dir_all;
        out_ff <= dat_all & gpio_all & dir_all;
        func_ff <= `FUNC_IMPL & ~gpio_all;
        strobe_sel_ff <= arb_asg_ff[29];
    end
end

assign m_pin_o = rev8(out_ff[55:48]);
assign m_oe_o = rev8(oe_ff[55:48]);
assign m_func_o = rev8(func_ff[55:48]);
assign strobe_select_o = strobe_sel_ff;
assign a_pin_o = rev8(out_ff[47:40]);
assign a_oe_o = rev8(oe_ff[47:40]);
assign a_func_o = rev8(func_ff[47:40]);
assign b_pin_o = rev8(out_ff[39:32]);
assign b_oe_o = rev8(oe_ff[39:32]);
assign b_func_o = rev8(func_ff[39:32]);
assign i_pin_o = rev8(out_ff[31:24]);
assign i_oe_o = rev8(oe_ff[31:24]);
assign i_func_o = rev8(func_ff[31:24]);
assign j_pin_o = rev8(out_ff[23:16]);
assign j_oe_o = rev8(oe_ff[23:16]);
assign j_func_o = rev8(func_ff[23:16]);
assign k_pin_o = rev8(out_ff[15:8]);
assign k_oe_o = rev8(oe_ff[15:8]);
assign k_func_o = rev8(func_ff[15:8]);
assign l_pin_o = rev8(out_ff[7:0]);
assign l_oe_o = rev8(oe_ff[7:0]);
assign l_func_o = rev8(func_ff[7:0]);

endmodule

// file: verification/system_port_gpio_properties.sv
// Purpose: port-side timing and pin relations of the shared-pin port block
// Assumes: sees the top-level ports only
// Notes: address decode repeated here from the constants header
`timescale 1ns/1ps
`include "gpio_consts.vh"
module system_port_gpio_properties (
    input wire clk_i,
    input wire nrst_i,
    input wire [31:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    input wire supervisor_i,
    input wire [31:0] rdata_o,
    input wire acc_done_o,
    input wire acc_err_o,
    input wire ext_req_o,
    input wire ext_we_o,
    input wire [31:0] ext_addr_o,
    input wire [7:0] m_pin_o,
    input wire [7:0] m_oe_o,
    input wire [7:0] m_func_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire stb = wr_i | rd_i;
    wire m_a = addr_i == `ADDR_ARB_DIR || addr_i == `ADDR_ARB_ASG || addr_i == `ADDR_ARB_DAT;
    wire l_a = addr_i == `ADDR_ABP_ASG || addr_i == `ADDR_ABP_DAT ||
        addr_i == `ADDR_CTL_DIR || addr_i == `ADDR_CTL_ASG || addr_i == `ADDR_CTL_DAT;
    // data registers left out: their privilege depends on the user enable
    wire s_a = addr_i == `ADDR_ARB_DIR || addr_i == `ADDR_ARB_ASG || addr_i == `ADDR_CTL_DIR;
    ////////////////////////////////////////
    sequence s_long_req;
        stb && supervisor_i && l_a ##1 !ext_req_o;
    endsequence
    // a replaced port answers outside instead of refusing
    sequence s_user_req;
        stb && !supervisor_i && s_a ##1 !ext_req_o;
    endsequence
    property p_short_done; stb && supervisor_i && m_a |=> acc_done_o; endproperty
    a_short_done: assert property (p_short_done) else $error("short access not done");
    property p_long_done; s_long_req |=> acc_done_o; endproperty
    a_long_done: assert property (p_long_done) else $error("long access not done");
    property p_redirect;
        ext_req_o |-> !acc_done_o && ext_addr_o == $past(addr_i) && ext_we_o == $past(wr_i);
    endproperty
    a_redirect: assert property (p_redirect) else $error("bad external cycle");
    property p_refuse; s_user_req |-> acc_err_o && rdata_o == 32'h0; endproperty
    a_refuse: assert property (p_refuse) else $error("user access not refused");
    property p_rsvd; rd_i && addr_i == `ADDR_ARB_DIR |=> (rdata_o & ~`MASK_ARB_DD) == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
    property p_excl; (m_oe_o & m_func_o) == 8'h00; endproperty
    a_excl: assert property (p_excl) else $error("bus function pin driven as port");
    property p_drive; (m_pin_o & ~m_oe_o) == 8'h00 && m_oe_o[2:0] == 3'h0; endproperty
    a_drive: assert property (p_drive) else $error("pin driven while not output");
    property p_lag; $changed(m_oe_o) |-> $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3);
    endproperty
    a_lag: assert property (p_lag) else $error("pin direction moved without write");
endmodule
////////////////////////////////////////
bind system_port_gpio system_port_gpio_properties i_system_port_gpio_properties (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .supervisor_i(supervisor_i), .rdata_o(rdata_o), .acc_done_o(acc_done_o),
    .acc_err_o(acc_err_o), .ext_req_o(ext_req_o), .ext_we_o(ext_we_o),
    .ext_addr_o(ext_addr_o), .m_pin_o(m_pin_o), .m_oe_o(m_oe_o), .m_func_o(m_func_o)
);

// file: verification/pin_model.sv
// Purpose: far side of one eight-bit shared pin port
// Assumes: far side drives every pin the port leaves released
// Notes: no keeper, so a released pin shows the far level at once
`timescale 1ns/1ps
module pin_model (
    input wire [7:0] oe_i,
    input wire [7:0] out_i,
    input wire [7:0] far_i,
    output wire [7:0] lvl_o
);
    // port driver wins where enabled, avoiding a fight on the wire
    assign lvl_o = (oe_i & out_i) | (~oe_i & far_i);
endmodule

// file: verification/system_port_gpio_test.sv
// Purpose: register and pin scenarios for the shared-pin port block
// Assumes: 125 MHz clock, config word selects port I/O unless set
// Notes: each access waits out the long done before the next strobe
`timescale 1ns/1ps
`include "gpio_consts.vh"
module system_port_gpio_test;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg sup = 1'b1;
    reg [31:0] addr = 32'h0;
    reg [31:0] wdata = 32'h0;
    reg [31:0] cfg = 32'h0;
    reg [11:0] cs = 12'h000;
    reg [7:0] far_m = 8'h00;
    reg [7:0] far_x = 8'h00;
    integer n_fail = 0;
    integer num_checks = 0;
    integer cyc = 0;
    // answer seen after a strobe: err, ext request, done cycle 1, done cycle 2
    reg [3:0] ans = 4'h0;
    wire [31:0] rdata, eaddr, ewdata;
    wire done, err, ereq, ewe, strb;
    wire [7:0] m_lv, m_po, m_oe, m_fn, a_po, a_oe, a_fn, b_po, b_oe, b_fn;
    wire [7:0] i_lv, i_po, i_oe, i_fn, j_lv, j_po, j_oe, j_fn;
    wire [7:0] k_lv, k_po, k_oe, k_fn, l_lv, l_po, l_oe, l_fn;
    always #4 clk = ~clk;
    system_port_gpio i_system_port_gpio (
        .clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .supervisor_i(sup), .rdata_o(rdata), .acc_done_o(done), .acc_err_o(err),
        .cfg_word_i(cfg), .cs_select_i(cs), .ext_req_o(ereq), .ext_we_o(ewe),
        .ext_addr_o(eaddr), .ext_wdata_o(ewdata), .m_pin_i(m_lv), .m_pin_o(m_po),
        .m_oe_o(m_oe), .m_func_o(m_fn), .strobe_select_o(strb), .a_pin_o(a_po),
        .a_oe_o(a_oe), .a_func_o(a_fn), .b_pin_o(b_po), .b_oe_o(b_oe), .b_func_o(b_fn),
        .i_pin_i(i_lv), .i_pin_o(i_po), .i_oe_o(i_oe), .i_func_o(i_fn), .j_pin_i(j_lv),
        .j_pin_o(j_po), .j_oe_o(j_oe), .j_func_o(j_fn), .k_pin_i(k_lv), .k_pin_o(k_po),
        .k_oe_o(k_oe), .k_func_o(k_fn), .l_pin_i(l_lv), .l_pin_o(l_po), .l_oe_o(l_oe),
        .l_func_o(l_fn)
    );
    pin_model i_pin_model_m (.oe_i(m_oe), .out_i(m_po), .far_i(far_m), .lvl_o(m_lv));
    pin_model i_pin_model_i (.oe_i(i_oe), .out_i(i_po), .far_i(far_x), .lvl_o(i_lv));
    pin_model i_pin_model_j (.oe_i(j_oe), .out_i(j_po), .far_i(far_x), .lvl_o(j_lv));
    pin_model i_pin_model_k (.oe_i(k_oe), .out_i(k_po), .far_i(far_x), .lvl_o(k_lv));
    pin_model i_pin_model_l (.oe_i(l_oe), .out_i(l_po), .far_i(far_x), .lvl_o(l_lv));
    ////////////////////////////////////////
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk32(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task chk8(input [7:0] got, input [7:0] exp);
        begin
            chk32({24'h0, got}, {24'h0, exp});
        end
    endtask
    task wreg(input [31:0] a, input [31:0] d, input s);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            sup <= s;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            #1;
            ans[3:1] = {err, ereq, done};
            @(posedge clk);
            #1;
            ans[0] = done;
            // covers long done plus the extra pin lag
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task rchk(input [31:0] a, input s, input [31:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            sup <= s;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1;
            chk32(rdata, exp);
            ans[3:1] = {err, ereq, done};
            @(posedge clk);
            #1;
            ans[0] = done;
            @(posedge clk);
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail = n_fail + 1;
            end_sim;
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(`ADDR_ARB_DIR, 1'b1, `RST_DIR);
        chk8({4'h0, ans}, 8'h02);
        rchk(`ADDR_ARB_ASG, 1'b1, 32'h0);
        rchk(`ADDR_ABP_ASG, 1'b1, 32'hFFF00000);
        chk8(a_fn, 8'hFF);
        chk8(b_fn, 8'h0F);
        rchk(`ADDR_CTL_DIR, 1'b1, 32'h0);
        chk8({4'h0, ans}, 8'h01);
        rchk(`ADDR_CTL_ASG, 1'b1, 32'h0);
        chk8(j_fn | k_fn | l_fn, 8'h00);
        rchk(32'h8007FC6C, 1'b1, 32'h0);
        chk8({4'h0, ans}, 8'h00);
        wreg(`ADDR_ARB_DIR, 32'hFFFFFFFF, 1'b1);
        chk8({4'h0, ans}, 8'h02);
        rchk(`ADDR_ARB_DIR, 1'b1, 32'h1F000000);
        wreg(`ADDR_ARB_DAT, 32'h15000000, 1'b1);
        chk8(m_oe, 8'hF8);
        chk8(m_po, 8'hA8);
        wreg(`ADDR_ARB_DIR, 32'h03000000, 1'b1);
        @(posedge clk);
        far_m <= 8'h5A;
        rchk(`ADDR_ARB_DAT, 1'b1, 32'h19000000);
        wreg(`ADDR_ARB_ASG, 32'h3F000000, 1'b1);
        chk8(m_oe, 8'h00);
        chk8(m_fn, 8'hFC);
        chk8({7'h0, strb}, 8'h01);
        rchk(`ADDR_ARB_DAT, 1'b1, 32'h15000000);
        @(posedge clk);
        cs <= 12'h001;
        wreg(`ADDR_ABP_ASG, 32'h0, 1'b1);
        wreg(`ADDR_ABP_DAT, 32'hA5C3FFFF, 1'b1);
        chk8({4'h0, ans}, 8'h01);
        rchk(`ADDR_ABP_DAT, 1'b1, 32'hA5C30000);
        chk8(a_oe, 8'hFE);
        chk8(a_fn, 8'h01);
        chk8(a_po, 8'hA4);
        chk8(b_oe, 8'hFF);
        chk8(b_fn, 8'h00);
        chk8(b_po, 8'hC3);
        wreg(`ADDR_ARB_DIR, 32'h0, 1'b0);
        chk8({4'h0, ans}, 8'h08);
        rchk(`ADDR_ARB_DIR, 1'b1, 32'h03000000);
        rchk(`ADDR_ARB_DAT, 1'b0, 32'h0);
        chk8({4'h0, ans}, 8'h08);
        wreg(`ADDR_GPIO_CTRL, 32'h00000001, 1'b1);
        rchk(`ADDR_ARB_DAT, 1'b0, 32'h15000000);
        wreg(`ADDR_CTL_DIR, 32'hFF000000, 1'b1);
        wreg(`ADDR_CTL_DAT, 32'hFFFFFFFF, 1'b1);
        chk8(i_oe, 8'hFF);
        chk8(i_po, 8'hFF);
        chk8(j_oe, 8'h00);
        chk8(j_po, 8'h00);
        chk8(k_po | l_po | k_oe | l_oe, 8'h00);
        @(posedge clk);
        far_x <= 8'h0F;
        rchk(`ADDR_CTL_DAT, 1'b1, 32'hFF70F030);
        chk8({4'h0, ans}, 8'h01);
        wreg(`ADDR_CTL_ASG, 32'hFF000000, 1'b1);
        chk8(i_oe, 8'h00);
        chk8(i_fn, 8'hFF);
        @(posedge clk);
        nrst <= 1'b0;
        cfg <= 32'h00000040;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        wreg(`ADDR_CTL_DIR, 32'h12345678, 1'b1);
        chk8({4'h0, ans}, 8'h04);
        chk32(eaddr, `ADDR_CTL_DIR);
        chk32(ewdata, 32'h12345678);
        chk8({7'h0, ewe}, 8'h01);
        rchk(`ADDR_CTL_DIR, 1'b1, 32'h0);
        rchk(`ADDR_GPIO_CTRL, 1'b1, 32'h00000100);
        wreg(`ADDR_ARB_DIR, 32'h1F000000, 1'b1);
        rchk(`ADDR_ARB_DIR, 1'b1, 32'h1F000000);
        chk8({4'h0, ans}, 8'h02);
        end_sim;
    end
endmodule
